//--- logic/ihbi_pkg.sv
`default_nettype none
package ihbi_pkg;
  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int ADDR_W     = 11;
  localparam int DATA_W     = 8;
  localparam int DMA_CH     = 3;
  localparam int IRQ_LINES  = 5;
  localparam int FUNC_IRQS  = 4;
  localparam int FIFO_DEPTH = 4;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 100;
  localparam int RESET_MIN_NS  = 500;
  localparam int RESET_CYC     = (RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int IRQ_PULSE_NS  = 200;
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_NS     = 300;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // ---------------------------------------------------------------
  // decode and status layout
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] STATUS_OFS = 11'h001;
  localparam int                ST_FULL    = 0;
  localparam int                ST_EMPTY   = 1;
  localparam int                ST_OVF     = 2;
  localparam logic [DATA_W-1:0] IDLE_DATA  = 8'hFF;
  localparam logic [2:0]        SRC_EXT    = 3'h4;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IHBI_MODE_AT_A = 2'b00,
    IHBI_MODE_AT_B = 2'b01,
    IHBI_MODE_ALT  = 2'b10
  } ihbi_mode_t;
  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic              decode_en;
    logic              cs_en;
    ihbi_mode_t        mode;
    logic              demand;
    logic [2:0]        irq_src;
    logic [2:0]        irq_line;
    logic              irq_en;
    logic              shared_irq;
  } ihbi_cfg_t;
  localparam ihbi_cfg_t CFG_RST = '{base: 11'h000, decode_en: 1'h0, cs_en: 1'h0,
                                    mode: IHBI_MODE_AT_A, demand: 1'h0, irq_src: 3'h0,
                                    irq_line: 3'h0, irq_en: 1'h0, shared_irq: 1'h0};
  typedef enum logic [2:0] {
    IHBI_CMD_IO_RD  = 3'b000,
    IHBI_CMD_IO_WR  = 3'b001,
    IHBI_CMD_DMA_RD = 3'b010,
    IHBI_CMD_DMA_WR = 3'b011,
    IHBI_CMD_BUSRST = 3'b100
  } ihbi_cmd_t;
  typedef enum logic [2:0] {
    IHBI_H_IDLE   = 3'b000,
    IHBI_H_WAIT   = 3'b001,
    IHBI_H_SETUP  = 3'b010,
    IHBI_H_STROBE = 3'b011,
    IHBI_H_HOLD   = 3'b100,
    IHBI_H_RESET  = 3'b101
  } ihbi_hstate_t;
endpackage
`default_nettype wire

//--- logic/ihbi_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ihbi_if;
  import ihbi_pkg::*;
  logic [DATA_W-1:0]    data_h;
  logic                 data_h_oe_n;
  logic [DATA_W-1:0]    data_d;
  logic                 data_d_oe_n;
  logic [DATA_W-1:0]    data;
  logic                 ior_n;
  logic                 iow_n;
  logic                 aen;
  logic [ADDR_W-1:0]    addr;
  logic [DMA_CH-1:0]    drq;
  logic [DMA_CH-1:0]    dack_n;
  logic                 tc;
  logic                 external_decode_select_n;
  logic                 bus_reset;
  logic [IRQ_LINES-1:0] irq_d;
  logic [IRQ_LINES-1:0] irq_d_oe_n;
  logic [IRQ_LINES-1:0] irq;
  // ---------------------------------------------------------------
  // wire resolution, idle level high
  // ---------------------------------------------------------------
  assign data = !data_d_oe_n ? data_d : (!data_h_oe_n ? data_h : IDLE_DATA);
  for (genvar l = 0; l < IRQ_LINES; l++) begin : g_irq
    assign irq[l] = irq_d_oe_n[l] ? 1'h1 : irq_d[l];
  end
  modport dev (input data, ior_n, iow_n, aen, addr, dack_n, tc,
               external_decode_select_n, bus_reset,
               output data_d, data_d_oe_n, drq, irq_d, irq_d_oe_n);
  modport host (input data, drq, irq,
                output data_h, data_h_oe_n, ior_n, iow_n, aen, addr, dack_n, tc,
                external_decode_select_n, bus_reset);
endinterface
`default_nettype wire

//--- logic/ihbi_device.sv
`timescale 1ns/1ps
`default_nettype none
module ihbi_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // filling side
  input  wire logic         in_valid_in,
  output var  logic         in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // draining side
  output var  logic         out_valid_out,
  input  wire logic         out_ready_in,
  output var  logic [W-1:0] out_data_out
);
  localparam int CW = $clog2(DEPTH + 1);
  if (DEPTH < 2) begin : g_chk
    $error("fifo depth below two");
  end
  logic [W-1:0]  mem [DEPTH];
  logic [W-1:0]  next_mem [DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          valid;
  logic          next_valid;
  logic          push;
  logic          pop;
  assign in_ready_out  = (count != CW'(DEPTH));
  assign out_valid_out = valid;
  assign out_data_out  = mem[0];
  always_comb begin
    int unsigned idx;
    idx        = 0;
    push       = in_valid_in && in_ready_out;
    pop        = out_ready_in && out_valid_out;
    next_mem   = mem;
    next_count = count + CW'(push) - CW'(pop);
    next_valid = (next_count != '0);
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_mem[i] = mem[i + 1];
      end
    end
    if (push) begin
      idx           = pop ? int'(count) - 1 : int'(count);
      next_mem[idx] = in_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count <= '0;
      valid <= 1'h0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      count <= next_count;
      valid <= next_valid;
      mem   <= next_mem;
    end
  end
endmodule

module ihbi_device
  import ihbi_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // bus
  ihbi_if.dev                        bus,
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // configuration
  input  wire logic                  cfg_load_in,
  input  wire ihbi_cfg_t             cfg_in,
  // interrupt sources
  input  wire logic [FUNC_IRQS-1:0]  irq_src_in,
  input  wire logic                  external_interrupt_input_in,
  // read data and dma requests
  input  wire logic [DATA_W-1:0]     rd_data_in,
  output var  logic                  rd_taken_out,
  input  wire logic [DMA_CH-1:0]     dma_req_in,
  output var  logic [DMA_CH-1:0]     dma_done_out,
  output var  logic                  overflow_out,
  // write stream
  output var  logic                  wr_valid_out,
  input  wire logic                  wr_ready_in,
  output var  logic [DATA_W-1:0]     wr_data_out
);
  localparam int PW = $clog2(IRQ_PULSE_CYC + 1);
  // ---------------------------------------------------------------
  // configuration, untouched by bus reset
  // ---------------------------------------------------------------
  ihbi_cfg_t cfg;
  ihbi_cfg_t next_cfg;
  always_comb begin
    next_cfg = cfg_load_in ? cfg_in : cfg;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cfg <= CFG_RST;
    end else begin
      cfg <= next_cfg;
    end
  end
  // ---------------------------------------------------------------
  // function state
  // ---------------------------------------------------------------
  logic                 func_rst_n, next_func_rst_n;
  logic                 ior_q, iow_q, next_ior_q, next_iow_q;
  logic [DMA_CH-1:0]    dack_q, next_dack_q;
  logic [ADDR_W-1:0]    lat_addr, next_lat_addr;
  logic                 lat_aen, next_lat_aen;
  logic                 lat_cs_n, next_lat_cs_n;
  logic [DMA_CH-1:0]    lat_dack, next_lat_dack;
  logic [DATA_W-1:0]    wr_hold, next_wr_hold;
  logic [DMA_CH-1:0]    drq, next_drq;
  logic [DMA_CH-1:0]    tc_seen, next_tc_seen;
  logic [DMA_CH-1:0]    done, next_done;
  logic                 taken, next_taken;
  logic                 ovf, next_ovf;
  logic [DATA_W-1:0]    dout, next_dout;
  logic                 dout_oe_n, next_dout_oe_n;
  logic [IRQ_LINES-1:0] irq_v, next_irq_v;
  logic [IRQ_LINES-1:0] irq_oe_n, next_irq_oe_n;
  logic                 src_q, next_src_q;
  logic [PW-1:0]        pulse, next_pulse;
  logic                 fifo_ready, fifo_valid, push;
  logic                 ior_fall, iow_fall, ior_rise, iow_rise;
  logic                 sel_ok, hit_data, hit_stat, dma_any, tc_act, src;
  logic [DATA_W-1:0]    status;
  ihbi_fifo #(.W(DATA_W), .DEPTH(DEPTH)) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (func_rst_n),
    .in_valid_in   (push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (wr_hold),
    .out_valid_out (fifo_valid),
    .out_ready_in  (wr_ready_in),
    .out_data_out  (wr_data_out)
  );
  assign wr_valid_out = fifo_valid;
  always_comb begin
    next_func_rst_n = rst_n_in && !bus.bus_reset;
    ior_fall = !bus.ior_n && ior_q;
    iow_fall = !bus.iow_n && iow_q;
    ior_rise = bus.ior_n && !ior_q;
    iow_rise = bus.iow_n && !iow_q;
    next_ior_q  = bus.ior_n;
    next_iow_q  = bus.iow_n;
    next_dack_q = bus.dack_n;
    next_lat_addr = lat_addr;
    next_lat_aen  = lat_aen;
    next_lat_cs_n = lat_cs_n;
    next_lat_dack = lat_dack;
    if (ior_fall || iow_fall) begin
      next_lat_addr = bus.addr;
      next_lat_aen  = bus.aen;
      next_lat_cs_n = bus.external_decode_select_n;
      next_lat_dack = ~bus.dack_n;
    end
    sel_ok   = cfg.decode_en && !lat_aen
               && (!cfg.cs_en || !lat_cs_n);
    hit_data = sel_ok && (lat_addr == cfg.base);
    hit_stat = sel_ok && (lat_addr == cfg.base + STATUS_OFS);
    dma_any  = |lat_dack;
    status           = '0;
    status[ST_FULL]  = !fifo_ready;
    status[ST_EMPTY] = !fifo_valid;
    status[ST_OVF]   = ovf;
    // read drive
    next_dout_oe_n = !(!bus.ior_n && !ior_q && (hit_data || hit_stat || dma_any));
    next_dout      = hit_stat && !dma_any ? status : rd_data_in;
    next_taken     = ior_rise && (hit_data || dma_any);
    // write capture into the fifo
    next_wr_hold = !bus.iow_n ? bus.data : wr_hold;
    push         = iow_rise && (hit_data || dma_any);
    next_ovf     = (push && !fifo_ready) || (ovf && !(ior_rise && hit_stat && !dma_any));
    // dma channels
    tc_act = (cfg.mode == IHBI_MODE_ALT) ? !bus.tc : bus.tc;
    for (int c = 0; c < DMA_CH; c++) begin
      next_done[c]    = !bus.dack_n[c] && tc_act && !tc_seen[c];
      next_tc_seen[c] = next_done[c] || (tc_seen[c] && dma_req_in[c]);
      if (drq[c]) begin
        next_drq[c] = dma_req_in[c] && !next_done[c]
                      && !(!bus.dack_n[c] && dack_q[c])
                      && !(!bus.dack_n[c] && !dack_q[c] && ior_fall);
      end else begin
        next_drq[c] = dma_req_in[c] && !tc_seen[c] && fifo_ready
                      && bus.ior_n && bus.iow_n
                      && (bus.dack_n[c] || cfg.demand);
      end
    end
    // interrupt steering
    src = 1'h0;
    if (cfg.irq_src == SRC_EXT) begin
      src = external_interrupt_input_in;
    end else if (int'(cfg.irq_src) < FUNC_IRQS) begin
      src = irq_src_in[cfg.irq_src[1:0]];
    end
    next_src_q = src;
    next_pulse = (pulse != '0) ? pulse - PW'(1) : pulse;
    if (src && !src_q && cfg.irq_en && cfg.shared_irq) begin
      next_pulse = PW'(IRQ_PULSE_CYC);
    end
    for (int l = 0; l < IRQ_LINES; l++) begin
      if (cfg.shared_irq) begin
        next_irq_v[l]    = 1'h0;
        next_irq_oe_n[l] = !(cfg.irq_en && cfg.irq_line == 3'(l) && pulse != '0);
      end else begin
        next_irq_v[l]    = src;
        next_irq_oe_n[l] = !(cfg.irq_en && cfg.irq_line == 3'(l));
      end
    end
  end
  always_ff @(posedge clk_in) begin
    func_rst_n <= next_func_rst_n;
    if (!func_rst_n || !rst_n_in) begin
      {ior_q, iow_q, dack_q, lat_aen, lat_cs_n, dout_oe_n, irq_oe_n} <= '1;
      {lat_addr, lat_dack, wr_hold, drq, tc_seen, done, taken, ovf, dout, irq_v, src_q,
       pulse} <= '0;
    end else begin
      {ior_q, iow_q, dack_q, lat_aen, lat_cs_n, dout_oe_n, irq_oe_n} <= {next_ior_q,
        next_iow_q, next_dack_q, next_lat_aen, next_lat_cs_n, next_dout_oe_n, next_irq_oe_n};
      {lat_addr, lat_dack, wr_hold, drq, tc_seen, done, taken, ovf, dout, irq_v, src_q,
       pulse} <= {next_lat_addr, next_lat_dack, next_wr_hold, next_drq, next_tc_seen,
                  next_done, next_taken, next_ovf, next_dout, next_irq_v, next_src_q,
                  next_pulse};
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.data_d      = dout;
  assign bus.data_d_oe_n = dout_oe_n;
  assign bus.drq         = drq;
  assign bus.irq_d       = irq_v;
  assign bus.irq_d_oe_n  = irq_oe_n;
  assign rd_taken_out    = taken;
  assign dma_done_out    = done;
  assign overflow_out    = ovf;
endmodule
`default_nettype wire

//--- logic/ihbi_host.sv
`timescale 1ns/1ps
`default_nettype none
module ihbi_host
  import ihbi_pkg::*;
(
  // bus
  ihbi_if.host                       bus,
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // command
  input  wire logic                  cmd_valid_in,
  output var  logic                  cmd_ready_out,
  input  wire ihbi_cmd_t             cmd_kind_in,
  input  wire logic [ADDR_W-1:0]     cmd_addr_in,
  input  wire logic [DATA_W-1:0]     cmd_data_in,
  input  wire logic [1:0]            cmd_chan_in,
  input  wire logic                  cmd_last_in,
  input  wire logic                  cmd_select_in,
  input  wire logic                  tc_active_high_in,
  // answer
  output var  logic                  rsp_valid_out,
  output var  logic [DATA_W-1:0]     rsp_data_out,
  output var  logic [IRQ_LINES-1:0]  irq_level_out
);
  ihbi_hstate_t      st, next_st;
  ihbi_cmd_t         kind, next_kind;
  logic [2:0]        cnt, next_cnt;
  logic [1:0]        chan, next_chan;
  logic              last, next_last, sel, next_sel;
  logic              ready, next_ready, rsp, next_rsp;
  logic [DATA_W-1:0] rdat, next_rdat, wdat, next_wdat;
  logic [ADDR_W-1:0] addr, next_addr;
  logic              ior_n, next_ior_n, iow_n, next_iow_n, aen, next_aen;
  logic              tc, next_tc, cs_n, next_cs_n, doe_n, next_doe_n, brst, next_brst;
  logic [DMA_CH-1:0] dack_n, next_dack_n;
  logic [IRQ_LINES-1:0] irq_l;
  logic              is_dma, is_wr;
  always_comb begin
    next_st = st;  next_kind = kind;  next_cnt = cnt;  next_chan = chan;
    next_last = last;  next_sel = sel;  next_rdat = rdat;  next_wdat = wdat;
    next_addr = addr;  next_ior_n = ior_n;  next_iow_n = iow_n;  next_aen = aen;
    next_tc = tc;  next_cs_n = cs_n;  next_doe_n = doe_n;  next_brst = brst;
    next_dack_n = dack_n;  next_rsp = 1'h0;  next_ready = 1'h0;
    is_dma = (kind == IHBI_CMD_DMA_RD) || (kind == IHBI_CMD_DMA_WR);
    is_wr  = (kind == IHBI_CMD_IO_WR) || (kind == IHBI_CMD_DMA_WR);
    case (st)
      IHBI_H_IDLE: begin
        next_ready = 1'h1;
        if (cmd_valid_in && ready) begin
          next_ready = 1'h0;
          next_kind = cmd_kind_in;  next_addr = cmd_addr_in;  next_wdat = cmd_data_in;
          next_chan = cmd_chan_in;  next_last = cmd_last_in;  next_sel = cmd_select_in;
          if (cmd_kind_in == IHBI_CMD_BUSRST) begin
            next_st = IHBI_H_RESET;
            next_cnt = 3'(RESET_CYC);
            next_brst = 1'h1;
          end else if (cmd_kind_in == IHBI_CMD_DMA_RD || cmd_kind_in == IHBI_CMD_DMA_WR) begin
            next_st = IHBI_H_WAIT;
          end else begin
            next_st = IHBI_H_SETUP;
          end
        end
      end
      IHBI_H_WAIT: begin
        if (bus.drq[chan]) begin
          next_st = IHBI_H_SETUP;
        end
      end
      IHBI_H_SETUP: begin
        next_aen  = is_dma;
        next_cs_n = !(sel && !is_dma);
        next_doe_n = !is_wr;
        if (is_dma) begin
          next_dack_n[chan] = 1'h0;
          next_tc = (last == tc_active_high_in);
        end
        next_st = IHBI_H_STROBE;
        next_cnt = 3'(STROBE_CYC);
        next_ior_n = is_wr;
        next_iow_n = !is_wr;
      end
      IHBI_H_STROBE: begin
        next_cnt = cnt - 3'h1;
        if (cnt == 3'h1) begin
          next_rdat = bus.data;
          next_ior_n = 1'h1;
          next_iow_n = 1'h1;
          next_st = IHBI_H_HOLD;
        end
      end
      IHBI_H_HOLD: begin
        next_aen = 1'h0;  next_cs_n = 1'h1;  next_doe_n = 1'h1;
        next_dack_n = '1;  next_tc = !tc_active_high_in;
        next_rsp = 1'h1;
        next_st = IHBI_H_IDLE;
      end
      IHBI_H_RESET: begin
        next_cnt = cnt - 3'h1;
        if (cnt == 3'h1) begin
          next_brst = 1'h0;
          next_rsp = 1'h1;
          next_st = IHBI_H_IDLE;
        end
      end
      default: begin
        next_st = IHBI_H_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st <= IHBI_H_IDLE;  kind <= IHBI_CMD_IO_RD;  cnt <= 3'h0;  chan <= 2'h0;
      last <= 1'h0;  sel <= 1'h0;  ready <= 1'h0;  rsp <= 1'h0;
      rdat <= '0;  wdat <= '0;  addr <= '0;  ior_n <= 1'h1;  iow_n <= 1'h1;
      aen <= 1'h0;  tc <= 1'h0;  cs_n <= 1'h1;  doe_n <= 1'h1;  brst <= 1'h0;
      dack_n <= '1;  irq_l <= '0;
    end else begin
      st <= next_st;  kind <= next_kind;  cnt <= next_cnt;  chan <= next_chan;
      last <= next_last;  sel <= next_sel;  ready <= next_ready;  rsp <= next_rsp;
      rdat <= next_rdat;  wdat <= next_wdat;  addr <= next_addr;
      ior_n <= next_ior_n;  iow_n <= next_iow_n;  aen <= next_aen;  tc <= next_tc;
      cs_n <= next_cs_n;  doe_n <= next_doe_n;  brst <= next_brst;
      dack_n <= next_dack_n;  irq_l <= bus.irq;
    end
  end
  assign bus.data_h      = wdat;
  assign bus.data_h_oe_n = doe_n;
  assign bus.ior_n       = ior_n;
  assign bus.iow_n       = iow_n;
  assign bus.aen         = aen;
  assign bus.addr        = addr;
  assign bus.dack_n      = dack_n;
  assign bus.tc          = tc;
  assign bus.external_decode_select_n = cs_n;
  assign bus.bus_reset   = brst;
  assign cmd_ready_out   = ready;
  assign rsp_valid_out   = rsp;
  assign rsp_data_out    = rdat;
  assign irq_level_out   = irq_l;
endmodule
`default_nettype wire

//--- verif/ihbi_props.sv
`timescale 1ns/1ps
`default_nettype none
module ihbi_props
  import ihbi_pkg::*;
(
  // clock and reset
  input wire logic              clk_in,
  input wire logic              rst_n_in,
  // watched bus lines
  input wire logic              ior_n,
  input wire logic              iow_n,
  input wire logic              data_d_oe_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DMA_CH-1:0] drq,
  input wire logic [DMA_CH-1:0] dack_n,
  input wire logic              bus_reset
);
  // ---------------------------------------------------------------
  // bus checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence rd_fall;
    $fell(ior_n);
  endsequence
  sequence dma_rd;
    rd_fall ##0 (dack_n != '1);
  endsequence
  oe_read_a: assert property (!data_d_oe_n |-> !$past(ior_n))
    else $error("data driven outside a read");
  oe_release_a: assert property ($rose(ior_n) |=> data_d_oe_n)
    else $error("data not released after read");
  dma_path_a: assert property (dma_rd |-> ##[2:3] !data_d_oe_n)
    else $error("acknowledged read not driven");
  drq_clear_a: assert property ((drq & ~dack_n & ~$past(dack_n)) == '0)
    else $error("request held under acknowledge");
  drq_start_a: assert property (|(drq & ~$past(drq)) |-> $past(ior_n) && $past(iow_n))
    else $error("request raised during a strobe");
  rst_clear_a: assert property (bus_reset && $past(bus_reset, 2) |-> drq == '0)
    else $error("request survives bus reset");
  rst_width_a: assert property ($rose(bus_reset) |=> bus_reset [*4])
    else $error("bus reset too short");
  strobe_excl_a: assert property (ior_n || iow_n)
    else $error("both strobes low");
  addr_hold_a: assert property (!ior_n && !$past(ior_n) |-> $stable(addr))
    else $error("address moved in strobe");
endmodule
`default_nettype wire

//--- verif/isa_host_bus_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("wrong value %s exp %h got %h", n, e, g); \
  end \
end
module isa_host_bus_interface_tb import ihbi_pkg::*;;
  // ---------------------------------------------------------------
  // stimulus and wiring
  // ---------------------------------------------------------------
  logic                 clk_in, rst_n_in, cmd_valid, cmd_last, cmd_sel, tc_hi;
  logic                 cfg_load, ext_irq, wr_rdy, cmd_ready, rsp_valid, ovf, wr_valid, taken;
  ihbi_cmd_t            kind;
  ihbi_cfg_t            cfg;
  logic [ADDR_W-1:0]    cmd_addr, base;
  logic [DATA_W-1:0]    cmd_data, rd_data, rsp_data, wr_data, d;
  logic [DATA_W-1:0]    q[$];
  logic [1:0]           chan;
  logic [FUNC_IRQS-1:0] irq_src;
  logic [DMA_CH-1:0]    dma_req, dma_done;
  logic [IRQ_LINES-1:0] irq_lvl;
  int                   mismatches, total_checks, done_cnt, n, seed;
  ihbi_if ihbi_if_i ();
  ihbi_host ihbi_host_i (.bus(ihbi_if_i), .clk_in(clk_in), .rst_n_in(rst_n_in),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_kind_in(kind),
    .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .cmd_chan_in(chan),
    .cmd_last_in(cmd_last), .cmd_select_in(cmd_sel), .tc_active_high_in(tc_hi),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .irq_level_out(irq_lvl));
  ihbi_device ihbi_device_i (.bus(ihbi_if_i), .clk_in(clk_in), .rst_n_in(rst_n_in),
    .cfg_load_in(cfg_load), .cfg_in(cfg), .irq_src_in(irq_src),
    .external_interrupt_input_in(ext_irq), .rd_data_in(rd_data), .rd_taken_out(taken),
    .dma_req_in(dma_req), .dma_done_out(dma_done), .overflow_out(ovf),
    .wr_valid_out(wr_valid), .wr_ready_in(wr_rdy), .wr_data_out(wr_data));
  ihbi_props ihbi_props_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .ior_n(ihbi_if_i.ior_n),
    .iow_n(ihbi_if_i.iow_n), .data_d_oe_n(ihbi_if_i.data_d_oe_n), .addr(ihbi_if_i.addr),
    .drq(ihbi_if_i.drq), .dack_n(ihbi_if_i.dack_n), .bus_reset(ihbi_if_i.bus_reset));
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (rst_n_in && (|dma_done === 1'h1)) done_cnt <= done_cnt + 1;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tmo();
    mismatches++;
    results();
  endtask
  task automatic cmd(input ihbi_cmd_t k, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] v, input logic [1:0] c, input logic l, s);
    @(posedge clk_in);
    {cmd_valid, kind, cmd_addr, cmd_data, rd_data} <= {1'h1, k, a, v, v};
    {chan, cmd_last, cmd_sel} <= {c, l, s};
    @(negedge clk_in);
    repeat (50) if (cmd_ready !== 1'h1) @(negedge clk_in);
    if (cmd_ready !== 1'h1) tmo();
    @(posedge clk_in);
    cmd_valid <= 1'h0;
    repeat (300) if (rsp_valid !== 1'h1) @(negedge clk_in);
    if (rsp_valid !== 1'h1) tmo();
  endtask
  task automatic setcfg(input ihbi_mode_t m, input logic [2:0] s, input logic sh);
    @(posedge clk_in);
    cfg <= '{base: base, decode_en: 1'h1, cs_en: 1'h1, mode: m, demand: 1'h0,
             irq_src: s, irq_line: 3'h1, irq_en: 1'h1, shared_irq: sh};
    cfg_load <= 1'h1;
    @(posedge clk_in);
    cfg_load <= 1'h0;
  endtask
  task automatic pop(input logic [DATA_W-1:0] e);
    @(posedge clk_in);
    wr_rdy <= 1'h1;
    @(negedge clk_in);
    `CK("wr_valid", 1'h1, wr_valid)
    `CK("wr_data", e, wr_data)
    @(posedge clk_in);
    wr_rdy <= 1'h0;
  endtask
  task automatic irq_set(input logic v, input logic [DATA_W-1:0] e);
    @(posedge clk_in);
    {irq_src[0], ext_irq} <= {v, !v};
    repeat (2) @(negedge clk_in);
    n = 0;
    repeat (10) begin
      @(negedge clk_in);
      n += (irq_lvl[1] === 1'h0);
    end
    `CK("irq_low", e, 8'(n))
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {rst_n_in, cmd_valid, cmd_last, tc_hi, cfg_load, ext_irq, wr_rdy} = '0;
    {cmd_sel, kind, cmd_addr, cmd_data, rd_data, chan} = {1'h1, IHBI_CMD_IO_RD, 29'h0};
    {cfg, irq_src, dma_req, mismatches, total_checks, done_cnt} = {CFG_RST, 7'h0, 96'h0};
    seed = 32'h9711FDFE;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'h1;
    base = 11'($random(seed)) & 11'h3FE;
    setcfg(IHBI_MODE_AT_A, 3'h0, 1'h0);
    d = 8'($random(seed));
    cmd(IHBI_CMD_IO_RD, base, d, 2'h0, 1'h0, 1'h1);
    `CK("read", d, rsp_data)
    `CK("rd_taken", 1'h1, taken)
    cmd(IHBI_CMD_IO_RD, base ^ 11'h400, d, 2'h0, 1'h0, 1'h1);
    `CK("alias", IDLE_DATA, rsp_data)
    `CK("rd_taken", 1'h0, taken)
    cmd(IHBI_CMD_IO_RD, base, d, 2'h0, 1'h0, 1'h0);
    `CK("no_select", IDLE_DATA, rsp_data)
    for (int i = 0; i < 5; i++) begin
      d = 8'($random(seed));
      if (i < 4) q.push_back(d);
      cmd(IHBI_CMD_IO_WR, base, d, 2'h0, 1'h0, 1'h1);
    end
    `CK("overflow", 1'h1, ovf)
    cmd(IHBI_CMD_IO_RD, base + 11'h001, d, 2'h0, 1'h0, 1'h1);
    `CK("status", 3'h5, rsp_data[2:0])
    cmd(IHBI_CMD_IO_RD, base + 11'h001, d, 2'h0, 1'h0, 1'h1);
    `CK("status", 3'h1, rsp_data[2:0])
    while (q.size() > 0) pop(q.pop_front());
    @(negedge clk_in);
    `CK("drained", 1'h0, wr_valid)
    for (int m = 0; m < 3; m++) for (int p = 0; p < 2; p++) begin
      setcfg(ihbi_mode_t'(m), 3'h0, 1'h0);
      {tc_hi, dma_req[m]} <= {m != 2, 1'h1};
      d = 8'($random(seed));
      n = done_cnt;
      cmd(p ? IHBI_CMD_DMA_RD : IHBI_CMD_DMA_WR, base, d, 2'(m), !p, 1'h1);
      @(posedge clk_in);
      dma_req <= '0;
      `CK("dma_done", n + !p, done_cnt)
      if (p) `CK("dma_read", d, rsp_data)
      else pop(d);
    end
    irq_set(1'h1, 8'h0);
    irq_set(1'h0, 8'hA);
    setcfg(IHBI_MODE_AT_A, SRC_EXT, 1'h0);
    irq_set(1'h0, 8'h0);
    setcfg(IHBI_MODE_AT_A, 3'h0, 1'h1);
    irq_set(1'h0, 8'h0);
    irq_set(1'h1, 8'(IRQ_PULSE_CYC));
    cmd(IHBI_CMD_IO_WR, base, d, 2'h0, 1'h0, 1'h1);
    cmd(IHBI_CMD_BUSRST, base, d, 2'h0, 1'h0, 1'h1);
    @(negedge clk_in);
    `CK("flushed", 1'h0, wr_valid)
    d = ~d;
    cmd(IHBI_CMD_IO_RD, base, d, 2'h0, 1'h0, 1'h1);
    `CK("cfg_kept", d, rsp_data)
    results();
  end
endmodule
`default_nettype wire
